// [common/adc_mux_defines.vh]
`ifndef ADC_MUX_DEFINES_VH
`define ADC_MUX_DEFINES_VH
// conversion time limit in microseconds and clock rate in MHz
`define CONV_TIME_US 40
`define CORE_CLK_MHZ 125
// longest time in core cycles: 40 us * 125 MHz = 5000
`define CONV_CYCLES (`CONV_TIME_US * `CORE_CLK_MHZ)
// successive approximation: one step per bit
`define SAR_BITS 8
// address field positions
`define ADDR_MODE_BIT 3
`define ADDR_PSEUDO_BIT 2
`define ADDR_PAIR_BIT 1
`define ADDR_POL_BIT 0
`define ADDR_BANK_BIT 4
// reset values
`define RESULT_RESET 8'h00
`define ADDR_RESET 5'h00
// selector codes: index of channel, analog_ground_pin is code 8
`define SEL_ANALOG_GROUND_PIN 4'h8
`endif

// [sim/adc_mux_bus_interface_tb_top.sv]
`timescale 1ns/1ps
module adc_mux_bus_interface_tb_top;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cs_n, wr_n, rd_n, done_n, busy;
	logic [7:0] bus, dout, oe, got;
	logic [3:0] pos, neg;
	logic [4:0] addr;
	logic [63:0] ach = 64'h0;
	int bad_count = 0;
	int num_checks = 0;
	int cyc_n = 0;
	// address, expected code
	logic [12:0] rows [7] = '{13'h0020, 13'h0100, 13'h0620, 13'h08f0,
		13'h0f10, 13'h18e0, 13'h1e20};
	adc_mux_bus_interface #(.EIGHT_CH(1), .CONV_CYCLES(80)) adc_mux_bus_interface_inst (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
		.cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
		.data_bus_lines_i(bus), .data_bus_lines_o(dout),
		.data_bus_lines_oe_o(oe), .conversion_done_n_o(done_n),
		.analog_channel_inputs_i(ach), .analog_ground_pin_i(8'h00),
		.input_selector_pos_o(pos), .input_selector_neg_o(neg),
		.mux_address_bits_o(addr), .busy_o(busy));
	host_bus_model host_bus_model_inst (.core_clk_i(core_clk_i),
		.dev_d_i(dout), .dev_oe_i(oe), .done_n_i(done_n), .cs_n_o(cs_n),
		.wr_n_o(wr_n), .rd_n_o(rd_n), .bus_o(bus));
	initial forever #4 core_clk_i = ~core_clk_i;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		// channel k falls by 8'h20 per step so every single-ended channel gives a distinct code
		for (int k = 0; k < 8; k++) ach[8*k+:8] = 8'hf0 - 8'(32 * k);
		repeat (3) @(negedge core_clk_i);
		rstn_i = 1'b1;
		check({7'h0, done_n}, 8'h01);
		check(oe, 8'h00);
		for (int i = 0; i < 7; i++) begin
			host_bus_model_inst.wr(rows[i][12:8], 1'b0);
			host_bus_model_inst.rd(got);
			check(got, rows[i][7:0]);
			check({3'h0, addr}, {3'h0, rows[i][12:8]});
			check({7'h0, done_n}, 8'h01);
			$display("row %0d done", i);
		end
		host_bus_model_inst.wr(5'h08, 1'b1);
		check({3'h0, addr}, 8'h1e);
		host_bus_model_inst.rd(got);
		check(got, 8'h20);
		$display("kept config test done");
		host_bus_model_inst.wr(5'h08, 1'b0);
		host_bus_model_inst.cyc(200);
		check({7'h0, done_n}, 8'h00);
		host_bus_model_inst.wr(5'h09, 1'b0);
		check({7'h0, done_n}, 8'h01);
		host_bus_model_inst.rd(got);
		check(got, 8'hd0);
		$display("unread result test done");
		close_out();
	end
endmodule

// [sim/adc_mux_props.sv]
`timescale 1ns/1ps
module adc_mux_props #(
	parameter CONV_CYCLES = 5000
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic [7:0] data_bus_lines_i,
	input wire logic [7:0] data_bus_lines_oe_o,
	input wire logic conversion_done_n_o,
	input wire logic [3:0] input_selector_pos_o,
	input wire logic [3:0] input_selector_neg_o,
	input wire logic [4:0] mux_address_bits_o,
	input wire logic busy_o
);
	// slack covers the strobe filter and the result hand-off
	localparam int LIM = CONV_CYCLES + 60;
	// counts busy cycles with no result flagged; the limit is too long
	// for a delay range at the full conversion time
	int conv_cnt = 0;
	always @(posedge core_clk_i)
		conv_cnt <= (rstn_i && busy_o && conversion_done_n_o) ?
			conv_cnt + 1 : 0;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence rd_on;
		(!cs_n_i && !rd_n_i)[*6];
	endsequence
	sequence cs_idle;
		cs_n_i[*6];
	endsequence
	a_read_drive: assert property (rd_on |-> data_bus_lines_oe_o == 8'hff && conversion_done_n_o)
		else $error("read not served");
	a_bus_release: assert property (rd_n_i[*6] |-> data_bus_lines_oe_o == 8'h00)
		else $error("bus still driven");
	a_write_clear: assert property ((!cs_n_i && !wr_n_i)[*6] |-> conversion_done_n_o)
		else $error("done flag kept on write");
	a_done_hold: assert property (cs_idle ##0 !conversion_done_n_o |=> !conversion_done_n_o)
		else $error("done flag lost");
	a_conv_bound: assert property (conv_cnt < LIM)
		else $error("conversion too long");
	a_addr_take: assert property ($changed(mux_address_bits_o) |-> rd_n_i && mux_address_bits_o == data_bus_lines_i[4:0])
		else $error("bad address latch");
	a_diff_map: assert property (($stable(mux_address_bits_o) && !mux_address_bits_o[3])[*2] |-> input_selector_pos_o == {1'b0, mux_address_bits_o[2:0]} && input_selector_neg_o == {1'b0, mux_address_bits_o[2:1], ~mux_address_bits_o[0]})
		else $error("bad pair select");
	a_single_map: assert property (($stable(mux_address_bits_o) && mux_address_bits_o[4:3] == 2'b01)[*2] |-> input_selector_pos_o == {1'b0, mux_address_bits_o[2:0]} && input_selector_neg_o == 4'h8)
		else $error("bad single select");
	a_pseudo_map: assert property (($stable(mux_address_bits_o) && mux_address_bits_o[4:3] == 2'b11)[*2] |-> input_selector_pos_o == {1'b0, mux_address_bits_o[2:0]} && input_selector_neg_o == 4'h7)
		else $error("bad pseudo select");
endmodule
bind adc_mux_bus_interface adc_mux_props #(.CONV_CYCLES(CONV_CYCLES)) adc_mux_props_inst (.*);

// [sim/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
	input wire logic core_clk_i,
	input wire logic [7:0] dev_d_i,
	input wire logic [7:0] dev_oe_i,
	input wire logic done_n_i,
	output logic cs_n_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [7:0] bus_o
);
	logic [7:0] hd = 8'h00;
	logic hen = 1'b0;
	logic [7:0] last = 8'h00;
	// nobody drives: no pull, so show a changing level, never a stale one
	assign bus_o = |dev_oe_i ? dev_d_i : hen ? hd : ~last;
	always @(posedge core_clk_i) last <= bus_o;
	initial begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic wr(input logic [4:0] a, input logic rd_low);
		cs_n_o = 1'b0;
		rd_n_o = ~rd_low;
		hd = {3'h0, a};
		hen = ~rd_low;
		cyc(3);
		wr_n_o = 1'b0;
		cyc(10);
		wr_n_o = 1'b1;
		cyc(10);
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		hen = 1'b0;
		cyc(2);
	endtask
	task automatic rd(output logic [7:0] d);
		repeat (300) if (done_n_i) cyc(1);
		cyc(76);
		cs_n_o = 1'b0;
		rd_n_o = 1'b0;
		cyc(8);
		d = bus_o;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		cyc(8);
	endtask
endmodule

// [verilog/adc_mux_bus_interface.v]
`timescale 1ns/1ps
`include "adc_mux_defines.vh"
module adc_mux_bus_interface #(
	parameter EIGHT_CH = 1,
	parameter CONV_CYCLES = `CONV_CYCLES
) (
	input wire core_clk_i,
	input wire rstn_i,
	input wire ce_i,
	input wire cs_n_i,
	input wire wr_n_i,
	input wire rd_n_i,
	input wire [7:0] data_bus_lines_i,
	output reg [7:0] data_bus_lines_o,
	output reg [7:0] data_bus_lines_oe_o,
	output reg conversion_done_n_o,
	input wire [63:0] analog_channel_inputs_i,
	input wire [7:0] analog_ground_pin_i,
	output reg [3:0] input_selector_pos_o,
	output reg [3:0] input_selector_neg_o,
	output reg [4:0] mux_address_bits_o,
	output reg busy_o
);
	localparam ST_IDLE = 2'b00;
	localparam ST_WLOW = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam STEP = CONV_CYCLES / `SAR_BITS;

	reg [2:0] cs_s, wr_s, rd_s;
	reg [7:0] d1, d2, d3;
	reg cs_q, wr_q, rd_q;
	reg [7:0] data_q;
	reg [1:0] state;
	reg rd_low_all;
	reg [7:0] result;
	reg start;
	wire sar_busy, sar_done;
	wire [7:0] sar_result;
	reg [7:0] v_pos, v_neg;
	wire [4:0] next_addr;

	// mode decode: returns {pos,neg} selector codes, neg 8 means ground
	function [7:0] decode_sel;
		input [4:0] a;
		input eight;
		reg [2:0] base;
		begin
			base = 3'h0;
			if (!a[`ADDR_MODE_BIT]) begin
				// pairs: channel index from pair bits, polarity bit 0
				base = eight ? {a[`ADDR_PSEUDO_BIT], a[`ADDR_PAIR_BIT], 1'b0}
					: {1'b0, a[`ADDR_PAIR_BIT], 1'b0};
				decode_sel = a[`ADDR_POL_BIT] ?
					{1'b0, base | 3'h1, 1'b0, base} :
					{1'b0, base, 1'b0, base | 3'h1};
			end else if (!(eight ? a[`ADDR_BANK_BIT] : a[`ADDR_PSEUDO_BIT]))
			begin
				base = eight ? a[2:0] : {1'b0, a[1:0]};
				decode_sel = {1'b0, base, `SEL_ANALOG_GROUND_PIN};
			end else begin
				base = eight ? a[2:0] : {1'b0, a[1:0]};
				decode_sel = eight ? {1'b0, base, 4'h7} :
					{1'b0, base, 4'h3};
			end
		end
	endfunction

	// low bits of the bus double as address; fifth bit only when eight ch
	assign next_addr = EIGHT_CH ? data_q[4:0] :
		{1'b0, data_q[3:0]};

	// analog inputs arrive as 8-bit samples per channel
	always @* begin
		v_pos = analog_channel_inputs_i[input_selector_pos_o[2:0]*8 +: 8];
		if (input_selector_neg_o == `SEL_ANALOG_GROUND_PIN)
			v_neg = analog_ground_pin_i;
		else
			v_neg = analog_channel_inputs_i[input_selector_neg_o[2:0]*8 +: 8];
	end

	// strobes come from a foreign bus: three stages, act when last two agree
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_s <= 3'b111;
			wr_s <= 3'b111;
			rd_s <= 3'b111;
			d1 <= 8'h00;
			d2 <= 8'h00;
			d3 <= 8'h00;
			cs_q <= 1'b1;
			wr_q <= 1'b1;
			rd_q <= 1'b1;
			data_q <= 8'h00;
		end else if (ce_i) begin
			cs_s <= {cs_s[1:0], cs_n_i};
			wr_s <= {wr_s[1:0], wr_n_i};
			rd_s <= {rd_s[1:0], rd_n_i};
			d1 <= data_bus_lines_i;
			d2 <= d1;
			d3 <= d2;
			if (cs_s[1] == cs_s[2])
				cs_q <= cs_s[2];
			if (wr_s[1] == wr_s[2])
				wr_q <= wr_s[2];
			if (rd_s[1] == rd_s[2])
				rd_q <= rd_s[2];
			if (d2 == d3)
				data_q <= d3;
		end
	end

	sar_engine #(
		.STEP_CYCLES(STEP)
	) u_sar (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.start_i(start),
		.diff_pos_i(v_pos),
		.diff_neg_i(v_neg),
		.busy_o(sar_busy),
		.done_o(sar_done),
		.result_o(sar_result)
	);

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= ST_IDLE;
			rd_low_all <= 1'b0;
			start <= 1'b0;
			result <= `RESULT_RESET;
			conversion_done_n_o <= 1'b1;
			data_bus_lines_o <= 8'h00;
			data_bus_lines_oe_o <= 8'h00;
			input_selector_pos_o <= 4'h0;
			input_selector_neg_o <= 4'h1;
			mux_address_bits_o <= `ADDR_RESET;
			busy_o <= 1'b0;
		end else if (ce_i) begin
			start <= 1'b0;
			busy_o <= sar_busy | start | (state != ST_IDLE);
			// drive bus only during an active read
			if (!cs_q && !rd_q) begin
				data_bus_lines_o <= result;
				data_bus_lines_oe_o <= 8'hff;
			end else begin
				data_bus_lines_oe_o <= 8'h00;
			end
			case (state)
			ST_IDLE, ST_CONV: begin
				if (!cs_q && !wr_q) begin
					conversion_done_n_o <= 1'b1;
					rd_low_all <= !rd_q;
					state <= ST_WLOW;
				end else if (state == ST_CONV && sar_done) begin
					result <= sar_result;
					state <= ST_IDLE;
				end
			end
			ST_WLOW: begin
				if (rd_q)
					rd_low_all <= 1'b0;
				if (wr_q || cs_q) begin
					// rd low over the whole pulse keeps old config
					if (rd_q && !rd_low_all) begin
						mux_address_bits_o <= next_addr;
						{input_selector_pos_o, input_selector_neg_o} <=
							decode_sel(next_addr, EIGHT_CH != 0);
					end
					start <= 1'b1;
					state <= ST_CONV;
				end
			end
			default: state <= ST_IDLE;
			endcase
			// flag falls in the same cycle the result lands, cleared by read
			if (!cs_q && !rd_q)
				conversion_done_n_o <= 1'b1;
			if (state == ST_CONV && sar_done && (cs_q || wr_q))
				conversion_done_n_o <= 1'b0;
		end
	end
endmodule

// [verilog/sar_engine.v]
`timescale 1ns/1ps
`include "adc_mux_defines.vh"
// comparator-based successive approximation; each bit gets an equal slice
module sar_engine #(
	parameter STEP_CYCLES = 625
) (
	input wire core_clk_i,
	input wire rstn_i,
	input wire ce_i,
	input wire start_i,
	input wire [7:0] diff_pos_i,
	input wire [7:0] diff_neg_i,
	output reg busy_o,
	output reg done_o,
	output reg [7:0] result_o
);
	reg [15:0] step_cnt;
	reg [3:0] bit_idx;
	reg [7:0] trial;
	wire [7:0] cand;
	wire [8:0] span;

	// negative input above positive gives zero via the clamp
	assign span = (diff_pos_i >= diff_neg_i) ?
		{1'b0, diff_pos_i - diff_neg_i} : 9'h000;
	assign cand = trial | (8'h80 >> bit_idx[2:0]);

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			result_o <= 8'h00;
			step_cnt <= 16'h0000;
			bit_idx <= 4'h0;
			trial <= 8'h00;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_o <= 1'b1;
				step_cnt <= 16'h0000;
				bit_idx <= 4'h0;
				trial <= 8'h00;
			end else if (busy_o) begin
				if (step_cnt == STEP_CYCLES[15:0] - 16'h0001) begin
					step_cnt <= 16'h0000;
					if ({1'b0, cand} <= span)
						trial <= cand;
					if (bit_idx == 4'h7) begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
						result_o <= ({1'b0, cand} <= span) ?
							cand : trial;
					end
					bit_idx <= bit_idx + 4'h1;
				end else begin
					step_cnt <= step_cnt + 16'h0001;
				end
			end
		end
	end
endmodule
